// ### mtx_exec.sv
// Execution unit for word mask test, byte exclusive-OR, register swap and wait.
`timescale 1ns/1ps
`include "mtx_defs.svh"
module mtx_exec
   import mtx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input mtx_req_t req,
   input wire logic [7:0] flagsIn,
   input wire logic memDone,
   input wire logic [15:0] memRdata,
   input wire logic intAck,
   output logic busy,
   output logic done,
   output logic [7:0] flagsOut,
   output logic flagsWe,
   output mtx_rfw_t rfWrite,
   output mtx_rfw_t rfWrite2,
   output mtx_mem_t memReq,
   output logic halted
);
   // Sequencer states. A request is only taken in the idle state, so any strobe that
   // arrives while an operation runs is ignored without notice; decode must hold it off.
   // The fetch states keep the memory read asserted until the memory answers, which
   // lets a slow memory stretch an operation by any number of cycles.
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_FETCH_SRC,
      ST_FETCH_DST,
      ST_EXEC,
      ST_STORE,
      ST_WAIT
   } mtx_state_t;

   // Sequencer state and the request captured when it was taken.
   mtx_state_t state_q, state_d;
   mtx_req_t r_q, r_d;
   // Operand values: taken from the request, or replaced by read data from memory.
   logic [15:0] sv_q, sv_d;
   logic [15:0] dv_q, dv_d;
   // Every output below is a register, so downstream paths see no logic from this unit.
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [7:0] flags_q, flags_d;
   logic flagsWe_q, flagsWe_d;
   mtx_rfw_t rfw_q, rfw_d;
   mtx_rfw_t rfw2_q, rfw2_d;
   mtx_mem_t mem_q, mem_d;
   logic halted_q, halted_d;

   // Logic flags shared by both widths: Z, S from the top bit, V cleared, rest kept.
   function automatic logic [7:0] mtxLogicFlags(input logic [7:0] f, input logic [15:0] res,
                                                input logic word);
      logic [7:0] o;
      o = f;
      o[`MTX_FLAG_Z] = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
      o[`MTX_FLAG_S] = word ? res[15] : res[7];
      o[`MTX_FLAG_V] = 1'b0;
      return o;
   endfunction

   // Step applied to the address pair for the current width.
   function automatic logic [15:0] mtxStep(input mtx_op_t op);
      return (op == MTX_OP_TMW) ? `MTX_WORD_STEP : `MTX_BYTE_STEP;
   endfunction

   // Sequencer: fetch operands, compute, write back, adjust pair.
   always_comb
   begin
      logic [15:0] res;
      logic word;
      res = 16'h0000;
      word = (r_q.op == MTX_OP_TMW);
      state_d = state_q;
      r_d = r_q;
      sv_d = sv_q;
      dv_d = dv_q;
      busy_d = busy_q;
      done_d = 1'b0;
      flags_d = flags_q;
      flagsWe_d = 1'b0;
      rfw_d = '0;
      rfw2_d = '0;
      mem_d = mem_q;
      halted_d = halted_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (reqValid)
            begin
               r_d = req;
               sv_d = req.srcVal;
               dv_d = req.dstVal;
               busy_d = 1'b1;
               if (req.op == MTX_OP_WAIT)
               begin
                  // Only instruction flow stops; DMA arbitration stays outside and runs on.
                  state_d = ST_WAIT;
                  halted_d = 1'b1;
               end
               else if (req.op == MTX_OP_SWAP)
               begin
                  state_d = ST_EXEC;
               end
               else
               begin
                  // The pre-decrement form adjusts the address before any fetch.
                  if (req.idx == MTX_IDX_PREDEC)
                  begin
                     r_d.srcAddr = req.srcAddr - mtxStep(req.op);
                     r_d.dstAddr = req.dstAddr - mtxStep(req.op);
                  end
                  state_d = req.srcMem ? ST_FETCH_SRC : (req.dstMem ? ST_FETCH_DST : ST_EXEC);
                  if (req.srcMem || req.dstMem)
                  begin
                     mem_d.rd = 1'b1;
                     mem_d.wr = 1'b0;
                     mem_d.word = (req.op == MTX_OP_TMW);
                     mem_d.addr = req.srcMem ? r_d.srcAddr : r_d.dstAddr;
                  end
               end
            end
         end
         ST_FETCH_SRC:
         begin
            // The source read completes first; the destination read, if any, follows
            // straight on without releasing the read strobe, so no idle cycle is lost.
            // The same read data port serves both, so the order of reads is fixed.
            if (memDone)
            begin
               sv_d = memRdata;
               mem_d.rd = r_q.dstMem;
               mem_d.addr = r_q.dstAddr;
               state_d = r_q.dstMem ? ST_FETCH_DST : ST_EXEC;
            end
         end
         ST_FETCH_DST:
         begin
            // Destination read: the word or byte that the operation combines with.
            // For the mask test this value is only looked at, never written back.
            if (memDone)
            begin
               dv_d = memRdata;
               mem_d.rd = 1'b0;
               state_d = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            // One cycle of arithmetic. Flags start from the flag register as it stands
            // now, so bits that the operation does not own pass through unchanged.
            // A memory-destination exclusive-OR result moves on to the store state instead of ending.
            state_d = ST_IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
            unique case (r_q.op)
               MTX_OP_TMW:
               begin
                  // Mask test: no destination write of any kind.
                  res = sv_q & dv_q;
                  flags_d = mtxLogicFlags(flagsIn, res, 1'b1);
                  flagsWe_d = 1'b1;
               end
               MTX_OP_XOR:
               begin
                  res = {8'h00, sv_q[7:0] ^ dv_q[7:0]};
                  flags_d = mtxLogicFlags(flagsIn, res, 1'b0);
                  flagsWe_d = 1'b1;
                  if (r_q.dstMem)
                  begin
                     mem_d.wr = 1'b1;
                     mem_d.word = 1'b0;
                     mem_d.addr = r_q.dstAddr;
                     mem_d.data = res;
                     state_d = ST_STORE;
                     busy_d = 1'b1;
                     done_d = 1'b0;
                  end
                  else
                  begin
                     rfw_d = '{en: 1'b1, word: 1'b0, addr: r_q.dstReg, data: res};
                  end
               end
               MTX_OP_SWAP:
               begin
                  // Both writes issue in one cycle so no flag path is touched.
                  rfw_d = '{en: 1'b1, word: 1'b0, addr: r_q.dstReg, data: sv_q};
                  rfw2_d = '{en: 1'b1, word: 1'b0, addr: r_q.srcReg, data: dv_q};
               end
               default:
               begin
                  res = 16'h0000;
               end
            endcase
            // Pair write-back: post-increment after the operation, or the pre-decremented value.
            if (r_q.idx != MTX_IDX_NONE && r_q.op != MTX_OP_SWAP)
            begin
               rfw2_d.en = 1'b1;
               rfw2_d.word = 1'b1;
               rfw2_d.addr = r_q.pairReg;
               if (r_q.idx == MTX_IDX_POSTINC)
               begin
                  rfw2_d.data = (r_q.srcMem ? r_q.srcAddr : r_q.dstAddr) + mtxStep(r_q.op);
               end
               else
               begin
                  rfw2_d.data = r_q.srcMem ? r_q.srcAddr : r_q.dstAddr;
               end
            end
         end
         ST_STORE:
         begin
            // The byte write stays asserted until the memory acknowledges it; the
            // completion pulse is held back until then so that a following
            // instruction cannot read the location before it holds the result.
            if (memDone)
            begin
               mem_d.wr = 1'b0;
               state_d = ST_IDLE;
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
         ST_WAIT:
         begin
            // Suspended: nothing is issued and no flag is written. Only the interrupt
            // acknowledge ends the wait; a new request strobe here is ignored.
            // Transfers by the DMA engine use the memory without this unit's help.
            if (intAck)
            begin
               state_d = ST_IDLE;
               halted_d = 1'b0;
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
         default:
         begin
            // An illegal state code falls back to idle rather than locking up.
            state_d = ST_IDLE;
         end
      endcase
   end

   // State registers; synchronous reset puts every output in a quiet state.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         r_q <= '0;
         sv_q <= 16'h0000;
         dv_q <= 16'h0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         flags_q <= `MTX_FLAGS_RST;
         flagsWe_q <= 1'b0;
         rfw_q <= '0;
         rfw2_q <= '0;
         mem_q <= '0;
         halted_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         r_q <= r_d;
         sv_q <= sv_d;
         dv_q <= dv_d;
         busy_q <= busy_d;
         done_q <= done_d;
         flags_q <= flags_d;
         flagsWe_q <= flagsWe_d;
         rfw_q <= rfw_d;
         rfw2_q <= rfw2_d;
         mem_q <= mem_d;
         halted_q <= halted_d;
      end
   end

   // Outputs come straight from the registers above.
   // No output carries any combinational path from an input.
   assign busy = busy_q;
   assign done = done_q;
   assign flagsOut = flags_q;
   assign flagsWe = flagsWe_q;
   assign rfWrite = rfw_q;
   assign rfWrite2 = rfw2_q;
   assign memReq = mem_q;
   assign halted = halted_q;
endmodule // mtx_exec

// ### mtx_defs.svh
// Constants for the mask test, exclusive-OR and exchange execution unit.
`ifndef MTX_DEFS_SVH
`define MTX_DEFS_SVH
`define MTX_FLAG_C 7
`define MTX_FLAG_Z 6
`define MTX_FLAG_S 5
`define MTX_FLAG_V 4
`define MTX_FLAG_D 3
`define MTX_FLAG_H 2
`define MTX_WORD_STEP 16'h0002
`define MTX_BYTE_STEP 16'h0001
`define MTX_FLAGS_RST 8'h00
`endif

// ### mtx_pkg.sv
// Types shared by the mask test, exclusive-OR and exchange execution unit.
package mtx_pkg;
   // Operation selected by the decoder in front of this unit.
   typedef enum logic [2:0]
   {
      MTX_OP_TMW,
      MTX_OP_XOR,
      MTX_OP_SWAP,
      MTX_OP_WAIT
   } mtx_op_t;
   // How the memory operand address pair is adjusted.
   typedef enum logic [1:0]
   {
      MTX_IDX_NONE,
      MTX_IDX_POSTINC,
      MTX_IDX_PREDEC
   } mtx_idx_t;
   // Request from decode: operands already resolved to values or addresses.
   typedef struct packed
   {
      mtx_op_t op;
      mtx_idx_t idx;
      logic srcMem;
      logic dstMem;
      logic [15:0] srcAddr;
      logic [15:0] dstAddr;
      logic [15:0] srcVal;
      logic [15:0] dstVal;
      logic [7:0] srcReg;
      logic [7:0] dstReg;
      logic [7:0] pairReg;
   } mtx_req_t;
   // Register file write request.
   typedef struct packed
   {
      logic en;
      logic word;
      logic [7:0] addr;
      logic [15:0] data;
   } mtx_rfw_t;
   // Memory access request.
   typedef struct packed
   {
      logic rd;
      logic wr;
      logic word;
      logic [15:0] addr;
      logic [15:0] data;
   } mtx_mem_t;
endpackage

// ### mtx_exec_checker.sv
// Port-level assertions for the execution unit.
`timescale 1ns/1ps
module mtx_exec_checker
   import mtx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input mtx_req_t req,
   input wire logic [7:0] flagsIn,
   input wire logic memDone,
   input wire logic [15:0] memRdata,
   input wire logic intAck,
   input wire logic busy,
   input wire logic done,
   input wire logic [7:0] flagsOut,
   input wire logic flagsWe,
   input mtx_rfw_t rfWrite,
   input mtx_rfw_t rfWrite2,
   input mtx_mem_t memReq,
   input wire logic halted
);
   logic take;
   logic [15:0] memA;
   mtx_op_t opD;
   mtx_op_t opQ;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // The kind of the running operation is kept, since completions are judged by kind.
   assign take = reqValid && !busy;
   assign memA = req.srcMem ? req.srcAddr : req.dstAddr;
   always_comb opD = take ? req.op : opQ;
   always_ff @(posedge clk) opQ <= opD;
   sequence s_regXor;
      take && req.op == MTX_OP_XOR && !req.srcMem && !req.dstMem;
   endsequence
   sequence s_regEnd;
      done && flagsWe && rfWrite.en;
   endsequence
   property p_regXor; s_regXor |-> ##2 s_regEnd; endproperty
   property p_preDec; take && req.idx == MTX_IDX_PREDEC && (req.srcMem || req.dstMem) |=>
      memReq.rd && memReq.addr == $past(memA) - (($past(req.op) == MTX_OP_TMW) ? 2 : 1);
   endproperty
   property p_rdHold; memReq.rd && !memDone |=> memReq.rd && $stable(memReq.addr); endproperty
   property p_tmwKeep; opQ == MTX_OP_TMW && (busy || done) |-> !rfWrite.en && !memReq.wr;
   endproperty
   property p_tmwFlags; done && opQ == MTX_OP_TMW |-> flagsWe; endproperty
   property p_vClear; flagsWe |-> !flagsOut[4]; endproperty
   property p_swap; done && opQ == MTX_OP_SWAP |-> rfWrite.en && rfWrite2.en && !flagsWe;
   endproperty
   property p_halt; halted |-> busy && !flagsWe && !done; endproperty
   property p_wake; halted && intAck |=> done && !halted; endproperty
   a_regXor: assert property (p_regXor) else $error("register xor late");
   a_preDec: assert property (p_preDec) else $error("bad predecrement");
   a_rdHold: assert property (p_rdHold) else $error("read dropped early");
   a_tmwKeep: assert property (p_tmwKeep) else $error("mask test wrote");
   a_tmwFlags: assert property (p_tmwFlags) else $error("mask test no flags");
   a_vClear: assert property (p_vClear) else $error("overflow not cleared");
   a_swap: assert property (p_swap) else $error("swap write wrong");
   a_halt: assert property (p_halt) else $error("wait not idle");
   a_wake: assert property (p_wake) else $error("wait did not end");
endmodule // mtx_exec_checker
bind mtx_exec mtx_exec_checker chk_u (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
   .flagsIn(flagsIn), .memDone(memDone), .memRdata(memRdata), .intAck(intAck), .busy(busy),
   .done(done), .flagsOut(flagsOut), .flagsWe(flagsWe), .rfWrite(rfWrite),
   .rfWrite2(rfWrite2), .memReq(memReq), .halted(halted));

// ### tb_mtx_exec.sv
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_mtx_exec
   import mtx_pkg::*;
;
   typedef struct packed {mtx_op_t op; mtx_idx_t idx; logic sm; logic dm; logic [15:0] sv;
      logic [15:0] dv; logic [15:0] adr; logic [15:0] md; logic [7:0] fin; logic [7:0] fexp;
   } mtx_row_t;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic reqValid = 1'h0;
   mtx_req_t req = '0;
   logic [7:0] flagsIn = 8'h00;
   logic memDone = 1'h0;
   logic [15:0] memRdata = 16'h0000;
   logic intAck = 1'h0;
   logic busy, done, flagsWe, halted;
   logic [7:0] flagsOut, gotFl;
   mtx_rfw_t rfWrite, rfWrite2;
   mtx_mem_t memReq;
   logic [15:0] rf [256];
   logic [15:0] gotRa, gotWd, md;
   int failures = 0, checksDone = 0, nFw, nRd, nWr;
   mtx_row_t w;
   mtx_row_t rows [13] = '{
      '{MTX_OP_XOR,MTX_IDX_NONE,1'h0,1'h0,16'h85,16'hCC,16'h0,16'h0,8'h9C,8'h8C},
      '{MTX_OP_XOR,MTX_IDX_NONE,1'h0,1'h0,16'h5A,16'h5A,16'h0,16'h0,8'h10,8'h40},
      '{MTX_OP_XOR,MTX_IDX_NONE,1'h0,1'h0,16'h80,16'h01,16'h0,16'h0,8'h40,8'h20},
      '{MTX_OP_TMW,MTX_IDX_NONE,1'h0,1'h0,16'hCCCC,16'h4848,16'h0,16'h0,8'h5C,8'h0C},
      '{MTX_OP_TMW,MTX_IDX_NONE,1'h0,1'h0,16'hCCCC,16'h3333,16'h0,16'h0,8'h00,8'h40},
      '{MTX_OP_SWAP,MTX_IDX_NONE,1'h0,1'h0,16'h12,16'h34,16'h0,16'h0,8'h00,8'h00},
      '{MTX_OP_TMW,MTX_IDX_PREDEC,1'h0,1'h1,16'hCCCC,16'h0,16'h4A0,16'hCCCC,8'h40,8'h20},
      '{MTX_OP_TMW,MTX_IDX_POSTINC,1'h0,1'h1,16'hCCCC,16'h0,16'h7D0,16'h3333,8'h00,8'h40},
      '{MTX_OP_TMW,MTX_IDX_NONE,1'h1,1'h1,16'h0,16'h0,16'h3EA,16'h0F0F,8'h80,8'h80},
      '{MTX_OP_XOR,MTX_IDX_PREDEC,1'h1,1'h0,16'h0,16'hCC,16'h1068,16'h85,8'h00,8'h00},
      '{MTX_OP_XOR,MTX_IDX_POSTINC,1'h1,1'h0,16'h0,16'hCC,16'h1068,16'hCC,8'h00,8'h40},
      '{MTX_OP_TMW,MTX_IDX_NONE,1'h0,1'h1,16'hFF00,16'h0,16'h2000,16'h8123,8'h00,8'h20},
      '{MTX_OP_XOR,MTX_IDX_POSTINC,1'h0,1'h1,16'h85,16'h0,16'hAF0,16'hCC,8'h00,8'h00}};
   mtx_exec dut_u (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .flagsIn(flagsIn),
      .memDone(memDone), .memRdata(memRdata), .intAck(intAck), .busy(busy), .done(done),
      .flagsOut(flagsOut), .flagsWe(flagsWe), .rfWrite(rfWrite), .rfWrite2(rfWrite2),
      .memReq(memReq), .halted(halted));
   initial forever #5 clk = ~clk;
   // Memory answers each read a cycle late; off-cycle data is inverted so stale data never passes.
   always @(posedge clk)
   begin
      memDone <= (memReq.rd || memReq.wr) && !memDone;
      memRdata <= (memReq.rd && !memDone) ? md : ~md;
      if (memReq.rd && !memDone)
      begin
         nRd++;
         if (nRd == 1) gotRa = memReq.addr;
      end
      if (memReq.wr && !memDone)
      begin
         nWr++;
         gotWd = memReq.data;
      end
      if (flagsWe)
      begin
         nFw++;
         gotFl = flagsOut;
      end
      if (rfWrite.en) rf[rfWrite.addr] = rfWrite.word ? rfWrite.data : {8'h00, rfWrite.data[7:0]};
      if (rfWrite2.en) rf[rfWrite2.addr] = rfWrite2.word ? rfWrite2.data : rfWrite2.data[7:0];
   end
   // One request strobe for a single cycle.
   task automatic send(input mtx_row_t r);
      @(posedge clk);
      reqValid <= 1'h1;
      req <= '{r.op, r.idx, r.sm, r.dm, r.adr, r.adr, r.sv, r.dv, 8'h20, 8'h30, 8'h20};
      flagsIn <= r.fin;
      md <= r.md;
      @(posedge clk);
      reqValid <= 1'h0;
   endtask
   // Done is looked at between edges; one more edge lets the bench capture the writes.
   task automatic waitDone;
      int n;
      n = 0;
      @(negedge clk);
      while (done !== 1'h1 && n < 80)
      begin
         @(negedge clk);
         n++;
      end
      if (done !== 1'h1) failures++;
      @(negedge clk);
   endtask
   // Register 20h stands for the source and the address pair, 30h for the destination.
   task automatic runRow(input mtx_row_t r);
      logic [15:0] st, pe, ed;
      logic [7:0] xr;
      st = (r.op == MTX_OP_TMW) ? 16'h0002 : 16'h0001;
      pe = (r.idx == MTX_IDX_PREDEC) ? r.adr - st : (r.idx == MTX_IDX_POSTINC) ? r.adr + st
         : (r.op == MTX_OP_SWAP) ? r.dv : 16'h0BAD;
      ed = (r.op == MTX_OP_SWAP) ? r.sv : 16'h0BAD;
      xr = (r.dm ? r.md[7:0] : r.dv[7:0]) ^ (r.sm ? r.md[7:0] : r.sv[7:0]);
      if (r.op == MTX_OP_XOR && !r.dm) ed = {8'h00, xr};
      gotWd = 16'h0BAD;
      rf[8'h20] = 16'h0BAD;
      rf[8'h30] = 16'h0BAD;
      nFw = 0;
      nRd = 0;
      nWr = 0;
      send(r);
      waitDone();
      if (r.op != MTX_OP_SWAP) `CHK(gotFl, r.fexp)
      `CHK(nFw, int'(r.op != MTX_OP_SWAP))
      `CHK(nRd, int'(r.sm) + int'(r.dm))
      `CHK(nWr, int'(r.op == MTX_OP_XOR && r.dm))
      `CHK(gotWd, (r.op == MTX_OP_XOR && r.dm) ? {8'h00, xr} : 16'h0BAD)
      if (nRd > 0) `CHK(gotRa, (r.idx == MTX_IDX_PREDEC) ? r.adr - st : r.adr)
      `CHK(rf[8'h20], pe)
      `CHK(rf[8'h30], ed)
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // A hang is cut short well after the hundred or so cycles the sequence needs.
   initial
   begin
      repeat (3000) @(posedge clk);
      failures++;
      close_out();
   end
   // Reset, the table, then the wait with a refused request and a reset in mid-access.
   initial
   begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK({busy, done, flagsWe, halted, memReq.rd, memReq.wr, rfWrite.en}, 7'h00)
      @(posedge clk) rst_n <= 1'h1;
      $display("test reset done");
      foreach (rows[i])
      begin
         runRow(rows[i]);
         $display("test row %0d done", i);
      end
      w = rows[0];
      w.op = MTX_OP_WAIT;
      nFw = 0;
      rf[8'h30] = 16'h0BAD;
      send(w);
      repeat (4) @(posedge clk);
      send(rows[0]);
      repeat (3) @(negedge clk);
      `CHK(halted, 1'h1)
      `CHK(rf[8'h30], 16'h0BAD)
      @(posedge clk) intAck <= 1'h1;
      @(posedge clk) intAck <= 1'h0;
      waitDone();
      `CHK(halted, 1'h0)
      `CHK(nFw, 0)
      $display("test wait done");
      send(rows[6]);
      @(posedge clk) rst_n <= 1'h0;
      @(posedge clk) rst_n <= 1'h1;
      @(negedge clk);
      `CHK({busy, memReq.rd}, 2'h0)
      runRow(rows[0]);
      $display("test mid reset done");
      close_out();
   end
endmodule // tb_mtx_exec
